/* hdl/nvmiac_params.svh */
// Constants for the indirect nonvolatile access controller.
// Included by the controller; holds definitions only.
`ifndef NVMIAC_PARAMS_SVH
`define NVMIAC_PARAMS_SVH

// Register offsets on the plain register port
`define NVM_OFS_DATA_LOW 9'h10c
`define NVM_OFS_ADDR_LOW 9'h10d
`define NVM_OFS_DATA_HIGH 9'h10e
`define NVM_OFS_ADDR_HIGH 9'h10f
`define NVM_OFS_CONTROL 9'h11b
`define NVM_OFS_UNLOCK 9'h11c
`define NVM_OFS_FLAGS 9'h120
`define NVM_OFS_MASK 9'h121

// Control register fields
`define NVM_BIT_RD 0
`define NVM_BIT_WR 1
`define NVM_BIT_WRITE_ENABLE_BIT 2
`define NVM_BIT_ERR 3
`define NVM_BIT_TIME_LO 4
`define NVM_BIT_TIME_HI 5
`define NVM_BIT_SPACE 7

// Flag and mask register field
`define NVM_BIT_DONE 0

// Values
`define NVM_UNLOCK_FIRST 8'h55
`define NVM_UNLOCK_SECOND 8'haa
`define NVM_ERASED 8'hff
`define NVM_ZERO8 8'h00
`define NVM_ZERO5 5'h00
`define NVM_ZERO2 2'h0

// Timing, clock period and programming limits in ns
`define NVM_CLK_NS 40
`define NVM_TLIM0_NS 1250000
`define NVM_TLIM1_NS 2500000
`define NVM_TLIM2_NS 5000000
`define NVM_TLIM3_NS 10000000
`define NVM_ERASE_NS 400000
`define NVM_PROG_NS 400000

`endif

/* hdl/nvmiac_pkg.sv */
// Types shared by the indirect nonvolatile access controller.
// No dependencies.
package nvmiac_pkg;
    typedef logic [19:0] nvmiac_cnt_t;
    typedef enum logic [1:0] {W_IDLE, W_ERASE, W_PROG, W_CHECK} nvmiac_wstate_t;
    typedef enum logic [1:0] {R_IDLE, R_FETCH, R_LATCH} nvmiac_rstate_t;
    typedef enum logic [1:0] {U_IDLE, U_HALF, U_ARMED} nvmiac_ustate_t;
endpackage

/* hdl/nvmiac_top.sv */
// Indirect access controller for a 128-byte data EEPROM and an 8K-word program memory.
// Assumes a single 25 MHz clock; register port, reset-cause and programmer
// inputs all come from logic on the same clock.
// Behaviour
// - 128-byte read/write EEPROM and 8K-word read-only program memory.
// - EEPROM access uses low data byte and low address register.
// - Program reads return 16-bit word from 13-bit two-register address.
// - Byte write erases the cell automatically, then programs it.
// - Time limit field bits 5:4 selects 1.25, 2.5, 5 or 10 ms.
// - Code protection blocks external programmer only, never the processor.
// - Space select bit 7 picks EEPROM at 0, program memory at 1; reset 0.
// - Read and write start bits set by software only, cleared by hardware.
// - EEPROM writes need write enable bit 2; cleared at power-on.
// - Error flag set on reset-abort or time limit; else 0 after completion.
// - Completion sets write done flag; only software clears it.
// - Unlock port has no storage and reads zero.
// - High address bits 7:5 read zero, bits 4:0 hold upper address.
// - Write starts only after 55h, AAh to unlock port, then start bit.
// - Start bit refused without write enable; hardware never clears enable.
// - Start bit with program memory selected never sets; it only consumes the unlock.
// - Read fetches in the second cycle, latches data on the next.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "nvmiac_params.svh"
`default_nettype none

module nvmiac_top #(
    parameter int TLIM0_NS = `NVM_TLIM0_NS,
    parameter int TLIM1_NS = `NVM_TLIM1_NS,
    parameter int TLIM2_NS = `NVM_TLIM2_NS,
    parameter int TLIM3_NS = `NVM_TLIM3_NS,
    parameter int ERASE_NS = `NVM_ERASE_NS,
    parameter int PROG_NS = `NVM_PROG_NS
) (
    // Clock and resets
    input wire logic mclk,
    input wire logic resetn,
    input wire logic por_n,
    // Register port
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt and processor hold
    output logic irq,
    output logic cpu_hold,
    // Reset causes that interrupt a write
    input wire logic watchdog_timer_reset,
    input wire logic undervoltage_reset,
    // External programmer port
    input wire logic code_protect,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic prog_space,
    input wire logic [12:0] prog_addr,
    input wire logic [15:0] prog_wdata,
    output logic [15:0] prog_rdata,
    output logic prog_denied
);

    // Limits round down so a write never runs past its slot; phases round up
    function automatic nvmiac_pkg::nvmiac_cnt_t cyc_down(input int ns);
        int c;
        c = ns / `NVM_CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return nvmiac_pkg::nvmiac_cnt_t'(c);
    endfunction

    function automatic nvmiac_pkg::nvmiac_cnt_t cyc_up(input int ns);
        int c;
        c = (ns + `NVM_CLK_NS - 1) / `NVM_CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return nvmiac_pkg::nvmiac_cnt_t'(c);
    endfunction

    localparam nvmiac_pkg::nvmiac_cnt_t LIM0_CYC = cyc_down(TLIM0_NS);
    localparam nvmiac_pkg::nvmiac_cnt_t LIM1_CYC = cyc_down(TLIM1_NS);
    localparam nvmiac_pkg::nvmiac_cnt_t LIM2_CYC = cyc_down(TLIM2_NS);
    localparam nvmiac_pkg::nvmiac_cnt_t LIM3_CYC = cyc_down(TLIM3_NS);
    localparam nvmiac_pkg::nvmiac_cnt_t ERASE_CYC = cyc_up(ERASE_NS);
    localparam nvmiac_pkg::nvmiac_cnt_t PROG_CYC = cyc_up(PROG_NS);

    // Time limit selected by the two-bit field
    function automatic nvmiac_pkg::nvmiac_cnt_t limit_for(input logic [1:0] sel);
        case (sel)
            2'h0: limit_for = LIM0_CYC;
            2'h1: limit_for = LIM1_CYC;
            2'h2: limit_for = LIM2_CYC;
            default: limit_for = LIM3_CYC;
        endcase
    endfunction

    // Write strobe hitting one offset
    function automatic logic wr_hit(input logic [8:0] ofs);
        return reg_wr && (reg_addr == ofs);
    endfunction

    // Storage
    logic [7:0] ee_mem [0:127];
    logic [15:0] pm_mem [0:8191];

    // Software visible state
    logic space_select_q;
    logic [1:0] time_sel_q;
    logic write_error_q;
    logic write_enable_q;
    logic read_start_q;
    logic program_go_q;
    logic [7:0] addr_low_q;
    logic [4:0] addr_high_q;
    logic [7:0] data_low_q;
    logic [7:0] data_high_q;
    logic done_flag_q;
    logic done_mask_q;
    logic [7:0] rdata_q;

    // Sequencer state
    nvmiac_pkg::nvmiac_ustate_t unlock_q;
    nvmiac_pkg::nvmiac_wstate_t wstate_q;
    nvmiac_pkg::nvmiac_rstate_t rstate_q;
    nvmiac_pkg::nvmiac_cnt_t elapsed_q;
    nvmiac_pkg::nvmiac_cnt_t phase_q;
    nvmiac_pkg::nvmiac_cnt_t limit_q;
    logic [6:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic [15:0] fetch_q;
    logic [15:0] prog_rdata_q;
    logic prog_denied_q;

    // Decoded events
    logic ctrl_wr;
    logic rd_set;
    logic go_req;
    logic go_ok;
    logic busy;
    logic abort;
    logic success;
    logic timeout;
    logic done_evt;
    logic prog_ok;
    logic ee_we;
    logic [6:0] ee_wa;
    logic [7:0] ee_wd;

    assign ctrl_wr = wr_hit(`NVM_OFS_CONTROL);
    assign busy = (wstate_q != nvmiac_pkg::W_IDLE);
    // Reads are refused while a read or write is already running
    assign rd_set = ctrl_wr && reg_wdata[`NVM_BIT_RD] && !busy && (rstate_q == nvmiac_pkg::R_IDLE);
    assign go_req = ctrl_wr && reg_wdata[`NVM_BIT_WR];
    // Start needs unlock, prior enable and EEPROM space; else the bit never sets
    assign go_ok = go_req && (unlock_q == nvmiac_pkg::U_ARMED)
        && write_enable_q
        && !reg_wdata[`NVM_BIT_SPACE]
        && !busy && (rstate_q == nvmiac_pkg::R_IDLE);
    assign abort = busy && (watchdog_timer_reset || undervoltage_reset);
    assign success = (wstate_q == nvmiac_pkg::W_CHECK) && (ee_mem[wr_addr_q] == wr_data_q);
    assign timeout = busy && !success && (elapsed_q >= limit_q - 1'b1);
    assign done_evt = !abort && (success || timeout);
    // Protection blocks only the external programmer path
    assign prog_ok = !code_protect && !busy;

    // Unlock sequence tracker; the port itself stores nothing
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            unlock_q <= nvmiac_pkg::U_IDLE;
        end else if (wr_hit(`NVM_OFS_UNLOCK)) begin
            if (reg_wdata == `NVM_UNLOCK_FIRST) begin
                unlock_q <= nvmiac_pkg::U_HALF;
            end else if (reg_wdata == `NVM_UNLOCK_SECOND && unlock_q == nvmiac_pkg::U_HALF) begin
                unlock_q <= nvmiac_pkg::U_ARMED;
            end else begin
                unlock_q <= nvmiac_pkg::U_IDLE;
            end
        end else if (go_req) begin
            unlock_q <= nvmiac_pkg::U_IDLE; // One start attempt consumes the unlock
        end
    end

    // Plain control fields written by software
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            space_select_q <= 1'b0;
            time_sel_q <= `NVM_ZERO2;
            write_enable_q <= 1'b0;
        end else if (ctrl_wr) begin
            space_select_q <= reg_wdata[`NVM_BIT_SPACE];
            time_sel_q <= reg_wdata[`NVM_BIT_TIME_HI:`NVM_BIT_TIME_LO];
            write_enable_q <= reg_wdata[`NVM_BIT_WRITE_ENABLE_BIT];
        end
    end

    // Error flag survives system resets so software can check after one
    always_ff @(posedge mclk) begin
        if (!por_n) begin
            write_error_q <= 1'b0;
        end else if (abort) begin
            write_error_q <= 1'b1;
        end else if (done_evt) begin
            write_error_q <= timeout;
        end else if (ctrl_wr) begin
            write_error_q <= reg_wdata[`NVM_BIT_ERR];
        end
    end

    // Start bits: software sets only, hardware clears on completion
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            read_start_q <= 1'b0;
            program_go_q <= 1'b0;
        end else begin
            if (rd_set) begin
                read_start_q <= 1'b1;
            end else if (rstate_q == nvmiac_pkg::R_LATCH) begin
                read_start_q <= 1'b0;
            end
            if (go_ok) begin
                program_go_q <= 1'b1;
            end else if (abort || done_evt) begin
                program_go_q <= 1'b0;
            end
        end
    end

    // Address registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            addr_low_q <= `NVM_ZERO8;
            addr_high_q <= `NVM_ZERO5;
        end else begin
            if (wr_hit(`NVM_OFS_ADDR_LOW)) begin
                addr_low_q <= reg_wdata;
            end
            if (wr_hit(`NVM_OFS_ADDR_HIGH)) begin
                addr_high_q <= reg_wdata[4:0];
            end
        end
    end

    // Write sequencer: erase, program, then self-check against the limit
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wstate_q <= nvmiac_pkg::W_IDLE;
            elapsed_q <= '0;
            phase_q <= '0;
            limit_q <= LIM0_CYC;
            wr_addr_q <= '0;
            wr_data_q <= `NVM_ZERO8;
        end else begin
            case (wstate_q)
                nvmiac_pkg::W_IDLE: begin
                    if (go_ok) begin
                        wstate_q <= nvmiac_pkg::W_ERASE;
                        elapsed_q <= '0;
                        phase_q <= '0;
                        limit_q <= limit_for(time_sel_q);
                        wr_addr_q <= addr_low_q[6:0];
                        wr_data_q <= data_low_q;
                    end
                end
                nvmiac_pkg::W_ERASE: begin
                    phase_q <= phase_q + 1'b1;
                    if (phase_q == ERASE_CYC - 1'b1) begin
                        phase_q <= '0;
                        wstate_q <= nvmiac_pkg::W_PROG;
                    end
                end
                nvmiac_pkg::W_PROG: begin
                    phase_q <= phase_q + 1'b1;
                    if (phase_q == PROG_CYC - 1'b1) begin
                        phase_q <= '0;
                        wstate_q <= nvmiac_pkg::W_CHECK;
                    end
                end
                nvmiac_pkg::W_CHECK: begin
                    wstate_q <= nvmiac_pkg::W_CHECK;
                end
                default: begin
                    wstate_q <= nvmiac_pkg::W_IDLE;
                end
            endcase
            if (busy) begin
                elapsed_q <= elapsed_q + 1'b1;
            end
            // A reset cause or completion ends any phase at once
            if (abort || done_evt) begin
                wstate_q <= nvmiac_pkg::W_IDLE;
            end
        end
    end

    // One EEPROM write port shared by the sequencer and the programmer
    always_comb begin
        ee_we = 1'b0;
        ee_wa = wr_addr_q;
        ee_wd = wr_data_q;
        if (!abort && wstate_q == nvmiac_pkg::W_ERASE && phase_q == ERASE_CYC - 1'b1) begin
            ee_we = 1'b1;
            ee_wd = `NVM_ERASED;
        end else if (!abort && wstate_q == nvmiac_pkg::W_PROG && phase_q == PROG_CYC - 1'b1) begin
            ee_we = 1'b1;
        end else if (prog_wr && !prog_space && prog_ok) begin
            ee_we = 1'b1;
            ee_wa = prog_addr[6:0];
            ee_wd = prog_wdata[7:0];
        end
    end

    // EEPROM array, only the low seven address bits decode
    always_ff @(posedge mclk) begin
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
    end

    // Program memory: read-only to the processor, loaded by the programmer
    always_ff @(posedge mclk) begin
        if (prog_wr && prog_space && prog_ok) begin
            pm_mem[prog_addr] <= prog_wdata;
        end
    end

    // Read sequencer: hold the processor for the fetch slot, then latch
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rstate_q <= nvmiac_pkg::R_IDLE;
            fetch_q <= '0;
        end else begin
            case (rstate_q)
                nvmiac_pkg::R_IDLE: begin
                    if (rd_set) begin
                        rstate_q <= nvmiac_pkg::R_FETCH;
                    end
                end
                nvmiac_pkg::R_FETCH: begin
                    rstate_q <= nvmiac_pkg::R_LATCH;
                    if (space_select_q) begin
                        fetch_q <= pm_mem[{addr_high_q, addr_low_q}];
                    end else begin
                        fetch_q <= {data_high_q, ee_mem[addr_low_q[6:0]]};
                    end
                end
                nvmiac_pkg::R_LATCH: begin
                    rstate_q <= nvmiac_pkg::R_IDLE;
                end
                default: begin
                    rstate_q <= nvmiac_pkg::R_IDLE;
                end
            endcase
        end
    end

    // Data registers: the read latch wins over a software write
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            data_low_q <= `NVM_ZERO8;
            data_high_q <= `NVM_ZERO8;
        end else begin
            if (rstate_q == nvmiac_pkg::R_LATCH) begin
                data_low_q <= fetch_q[7:0];
                data_high_q <= fetch_q[15:8];
            end else begin
                if (wr_hit(`NVM_OFS_DATA_LOW)) begin
                    data_low_q <= reg_wdata;
                end
                if (wr_hit(`NVM_OFS_DATA_HIGH)) begin
                    data_high_q <= reg_wdata;
                end
            end
        end
    end

    // Done flag: completion wins over a write-one clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            done_flag_q <= 1'b0;
            done_mask_q <= 1'b0;
        end else begin
            if (done_evt) begin
                done_flag_q <= 1'b1;
            end else if (wr_hit(`NVM_OFS_FLAGS) && reg_wdata[`NVM_BIT_DONE]) begin
                done_flag_q <= 1'b0;
            end
            if (wr_hit(`NVM_OFS_MASK)) begin
                done_mask_q <= reg_wdata[`NVM_BIT_DONE];
            end
        end
    end

    // External programmer reads; refused when protected or during a write
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prog_rdata_q <= '0;
            prog_denied_q <= 1'b0;
        end else begin
            prog_denied_q <= (prog_wr || prog_rd) && !prog_ok;
            if (prog_rd && prog_ok) begin
                if (prog_space) begin
                    prog_rdata_q <= pm_mem[prog_addr];
                end else begin
                    prog_rdata_q <= {`NVM_ZERO8, ee_mem[prog_addr[6:0]]};
                end
            end
        end
    end

    // Register read data, valid the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_q <= `NVM_ZERO8;
        end else if (reg_rd) begin
            case (reg_addr)
                `NVM_OFS_DATA_LOW: rdata_q <= data_low_q;
                `NVM_OFS_ADDR_LOW: rdata_q <= addr_low_q;
                `NVM_OFS_DATA_HIGH: rdata_q <= data_high_q;
                `NVM_OFS_ADDR_HIGH: rdata_q <= {3'h0, addr_high_q};
                `NVM_OFS_CONTROL: rdata_q <= {space_select_q, 1'b0, time_sel_q,
                    write_error_q, write_enable_q, program_go_q, read_start_q};
                `NVM_OFS_UNLOCK: rdata_q <= `NVM_ZERO8;
                `NVM_OFS_FLAGS: rdata_q <= {7'h00, done_flag_q};
                `NVM_OFS_MASK: rdata_q <= {7'h00, done_mask_q};
                default: rdata_q <= `NVM_ZERO8;
            endcase
        end else begin
            rdata_q <= `NVM_ZERO8;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign irq = done_flag_q && done_mask_q;
    assign cpu_hold = (rstate_q == nvmiac_pkg::R_FETCH);
    assign prog_rdata = prog_rdata_q;
    assign prog_denied = prog_denied_q;

endmodule
`default_nettype wire

/* tb/nvmiac_checker.sv */
// Port checker for the indirect nonvolatile access controller.
// Assumes one clock and a synchronous active-low reset; bound to nvmiac_top.
`timescale 1ns/1ns
`include "nvmiac_params.svh"
`default_nettype none

module nvmiac_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Interrupt and hold
    input wire logic irq,
    input wire logic cpu_hold,
    // Programmer port
    input wire logic code_protect,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [15:0] prog_rdata,
    input wire logic prog_denied
);
    // Everything here lives in the one system clock domain
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    chk_unlock_zero: assert property (reg_rd && reg_addr == `NVM_OFS_UNLOCK |=> reg_rdata == 8'h00)
        else $error("unlock port read back nonzero");
    chk_addrh_top: assert property (reg_rd && reg_addr == `NVM_OFS_ADDR_HIGH |=> reg_rdata[7:5] == 3'h0)
        else $error("high address spare bits nonzero");
    chk_hold_once: assert property ($rose(cpu_hold) |=> !cpu_hold)
        else $error("fetch hold longer than one cycle");
    // A fetch slot only ever follows a software start of a read
    chk_hold_cause: assert property ($rose(cpu_hold) |-> $past(reg_wr && reg_addr == `NVM_OFS_CONTROL && reg_wdata[0]))
        else $error("fetch hold without read start");
    chk_prot_deny: assert property ((prog_wr || prog_rd) && code_protect |=> prog_denied)
        else $error("protected programmer access not refused");
    chk_deny_cause: assert property (prog_denied |-> $past(prog_wr || prog_rd))
        else $error("refusal without programmer access");
    chk_prot_keep: assert property (code_protect |=> $stable(prog_rdata))
        else $error("programmer data moved while protected");
    chk_irq_mask: assert property (reg_wr && reg_addr == `NVM_OFS_MASK && !reg_wdata[0] |=> !irq)
        else $error("interrupt high while masked");
    chk_irq_fall: assert property ($fell(irq) |-> $past(reg_wr && (reg_addr == `NVM_OFS_FLAGS || reg_addr == `NVM_OFS_MASK)))
        else $error("interrupt dropped without software");

    cov_fetch: cover property ($rose(cpu_hold));
    cov_denied: cover property (prog_denied);
    cov_irq: cover property ($rose(irq));
endmodule

bind nvmiac_top nvmiac_checker u_nvmiac_checker (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .cpu_hold, .code_protect, .prog_wr, .prog_rd, .prog_rdata, .prog_denied);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the indirect nonvolatile access controller.
// Assumes nvmiac_top with shortened timing: erase and program 60 cycles each.
`timescale 1ns/1ns
`include "nvmiac_params.svh"
`default_nettype none

module tb_top;
    localparam logic [8:0] o_dl = `NVM_OFS_DATA_LOW;
    localparam logic [8:0] o_al = `NVM_OFS_ADDR_LOW;
    localparam logic [8:0] o_dh = `NVM_OFS_DATA_HIGH;
    localparam logic [8:0] o_ah = `NVM_OFS_ADDR_HIGH;
    localparam logic [8:0] o_ct = `NVM_OFS_CONTROL;
    localparam logic [8:0] o_un = `NVM_OFS_UNLOCK;
    localparam logic [8:0] o_fl = `NVM_OFS_FLAGS;
    localparam logic [8:0] o_mk = `NVM_OFS_MASK;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic por_n = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, watchdog_timer_reset = 1'b0, undervoltage_reset = 1'b0;
    logic code_protect = 1'b0, prog_wr = 1'b0, prog_rd = 1'b0, prog_space = 1'b0;
    logic [12:0] prog_addr = 13'h0000;
    logic [15:0] prog_wdata = 16'h0000;
    logic [7:0] reg_rdata;
    logic [15:0] prog_rdata;
    logic irq, cpu_hold, prog_denied;
    logic [7:0] exp_q[$];
    logic [16:0] pexp_q[$];
    logic rd_p = 1'b0, pr_p = 1'b0;
    int failures = 0, checks = 0, cyc = 0;

    // Limits of 100 to 300 cycles, the longest left at its default; only the shortest is below a full write
    nvmiac_top #(.TLIM0_NS(4000), .TLIM1_NS(8000), .TLIM2_NS(12000),
        .ERASE_NS(2400), .PROG_NS(2400)) u_nvmiac_top (.mclk, .resetn, .por_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .cpu_hold, .watchdog_timer_reset,
        .undervoltage_reset, .code_protect, .prog_wr, .prog_rd, .prog_space, .prog_addr,
        .prog_wdata, .prog_rdata, .prog_denied);

    // 25 MHz clock
    always #20 mclk = ~mclk;

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: register value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_prog(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: programmer result %h expected %h", $time, got, exp);
        end
    endtask

    // Results show one cycle after their strobe; oldest note is matched first
    always @(posedge mclk) begin
        if (rd_p)
            cmp_reg(reg_rdata, exp_q.pop_front());
        if (pr_p)
            cmp_prog({prog_denied, prog_rdata}, pexp_q.pop_front());
        rd_p <= reg_rd;
        pr_p <= prog_rd;
    end

    // Hang guard, well above the roughly 750 cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Strobes drop for a cycle between accesses so no signal is set twice in a step
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic prog_op(input logic w);
        prog_wr <= w;
        prog_rd <= !w;
        @(posedge mclk);
        prog_wr <= 1'b0;
        prog_rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic start_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] t);
        wr(o_dl, d);
        wr(o_al, a);
        wr(o_ct, {2'b00, t, 4'h4});
        wr(o_un, `NVM_UNLOCK_FIRST);
        wr(o_un, `NVM_UNLOCK_SECOND);
        wr(o_ct, {2'b00, t, 4'h6});
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 400 && irq !== 1'b1; i++)
            @(posedge mclk);
        cmp_reg({7'h00, irq}, 8'h01);
    endtask

    // Main sequence
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [12:0] pa;
        logic [15:0] pd;
        logic [1:0] t;
        void'($urandom(45504));
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge mclk);
        rd(o_ct, 8'h00);
        rd(o_ah, 8'h00);
        wr(o_ah, 8'hff);
        rd(o_ah, 8'h1f);
        wr(o_un, 8'h3c);
        rd(o_un, 8'h00);
        $display("test reset values done");
        wr(o_un, `NVM_UNLOCK_FIRST);
        wr(o_un, `NVM_UNLOCK_SECOND);
        wr(o_ct, 8'h02);
        rd(o_ct, 8'h00);
        wr(o_ct, 8'h04);
        wr(o_ct, 8'h06);
        rd(o_ct, 8'h04);
        wr(o_un, `NVM_UNLOCK_SECOND);
        wr(o_un, `NVM_UNLOCK_FIRST);
        wr(o_ct, 8'h06);
        rd(o_ct, 8'h04);
        $display("test refused starts done");
        // Same cell rewritten under every limit code; the shortest limit must expire
        a = 8'($urandom);
        wr(o_mk, 8'h01);
        for (int i = 0; i < 4; i++) begin
            t = i[1:0];
            d = 8'($urandom);
            start_write(a, d, t);
            wr(o_ct, {2'b00, t, 4'h4});
            rd(o_ct, {2'b00, t, 4'h6});
            wait_irq();
            rd(o_ct, {2'b00, t, (t == 2'b00), 3'h4});
            rd(o_fl, 8'h01);
            wr(o_mk, 8'h00);
            cmp_reg({7'h00, irq}, 8'h00);
            wr(o_mk, 8'h01);
            wr(o_fl, 8'h01);
            rd(o_fl, 8'h00);
            if (t != 2'b00) begin
                wr(o_al, a ^ 8'h80);
                wr(o_ct, 8'h01);
                repeat (2) @(posedge mclk);
                rd(o_dl, d);
            end
        end
        $display("test eeprom writes done");
        pa = 13'($urandom);
        pd = 16'($urandom);
        prog_space <= 1'b1;
        prog_addr <= pa;
        prog_wdata <= pd;
        prog_op(1'b1);
        code_protect <= 1'b1;
        wr(o_ah, {3'b000, pa[12:8]});
        wr(o_al, pa[7:0]);
        wr(o_ct, 8'h81);
        repeat (2) @(posedge mclk);
        rd(o_dl, pd[7:0]);
        rd(o_dh, pd[15:8]);
        pexp_q.push_back({1'b1, 16'h0000});
        prog_op(1'b0);
        code_protect <= 1'b0;
        pexp_q.push_back({1'b0, pd});
        prog_op(1'b0);
        // Programmer read of the EEPROM cell written last
        prog_space <= 1'b0;
        prog_addr <= {6'h00, a[6:0]};
        pexp_q.push_back({9'h000, d});
        prog_op(1'b0);
        wr(o_ct, 8'h84);
        wr(o_un, `NVM_UNLOCK_FIRST);
        wr(o_un, `NVM_UNLOCK_SECOND);
        wr(o_ct, 8'h86);
        rd(o_ct, 8'h84);
        $display("test program memory done");
        // Each reset cause aborts a running write without a done flag
        for (int k = 0; k < 2; k++) begin
            start_write(a, d, 2'b01);
            repeat (20) @(posedge mclk);
            {undervoltage_reset, watchdog_timer_reset} <= (k == 0) ? 2'b01 : 2'b10;
            @(posedge mclk);
            {undervoltage_reset, watchdog_timer_reset} <= 2'b00;
            @(posedge mclk);
            rd(o_ct, 8'h1c);
            rd(o_fl, 8'h00);
        end
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(o_ct, 8'h08);
        resetn <= 1'b0;
        por_n <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge mclk);
        rd(o_ct, 8'h00);
        $display("test aborts and resets done");
        repeat (3) @(posedge mclk);
        complete_run();
    end
endmodule
`default_nettype wire
